// >>> hdl/mon_pkg.sv
// constants and types for the monitor pulse output and hour meters
// assumes a single 10 MHz clock; settings are 16-bit decimal values
package mon_pkg;
    localparam int unsigned CLK_HZ      = 10_000_000;
    localparam int unsigned HOUR_S      = 3600;
    localparam logic [35:0] HOUR_CYC    = 36'(HOUR_S) * 36'(CLK_HZ);
    localparam int unsigned FULL_PPS    = 1440;
    localparam int unsigned MAX_PPS     = 2400;
    localparam int unsigned STEP_HZ     = 10_000;
    localparam int unsigned STEP_CYC    = CLK_HZ / STEP_HZ;
    localparam int unsigned MIN_PER_CYC = (CLK_HZ + MAX_PPS - 1) / MAX_PPS;
    localparam logic [9:0]  STEP_LAST   = 10'(STEP_CYC - 1);
    localparam logic [12:0] PER_LAST    = 13'(MIN_PER_CYC - 1);
    localparam logic [31:0] FULL_MUL    = 32'(FULL_PPS);
    localparam logic [31:0] STEP_MUL    = 32'(STEP_HZ);
    localparam logic [15:0] HOUR_MAX    = 16'hffff;
    localparam logic [15:0] KEEP        = 16'h270f;
    localparam logic [15:0] CLR_VAL     = 16'h0000;
    localparam logic [15:0] EN_MODE10   = 16'h000a;
    localparam logic [15:0] DEC_INT     = 16'h0000;
    localparam logic [15:0] DEC_TENTH   = 16'h0001;
    localparam logic [15:0] WP_LOCK     = 16'h0001;
    localparam logic [15:0] EXT_ALL     = 16'h0000;
    localparam logic [15:0] FREQ_REF_DEF = 16'h1770;
    localparam logic [15:0] FREQ_REF_MAX = 16'h9c40;
    localparam logic [15:0] CUR_REF_MAX  = 16'hc350;
    localparam logic [15:0] CAL_DEF     = 16'h07d0;
    localparam logic [15:0] BELOW_T     = 16'h000a;
    localparam logic [15:0] BELOW_H     = 16'h0063;
    localparam logic [16:0] DIV10       = 17'h0000a;
    localparam logic [16:0] HALF10      = 17'h00005;
    localparam logic [16:0] DIV100      = 17'h00064;
    localparam logic [16:0] HALF100     = 17'h00032;
    localparam logic [1:0]  DP_NONE     = 2'h0;
    localparam logic [1:0]  DP_TENTHS   = 2'h1;
    localparam logic [1:0]  DP_HUND     = 2'h2;
    localparam logic [7:0]  SEL_PON     = 8'h14;
    localparam logic [7:0]  SEL_RUN     = 8'h17;
    localparam logic [7:0]  SEL_ENERGY  = 8'h19;
    localparam logic [7:0]  FN_FREQ     = 8'h01;
    localparam logic [7:0]  FN_CURR     = 8'h02;
    localparam logic [7:0]  FN_REF      = 8'h15;
    typedef enum logic [3:0] {
        ID_RT_CLR, ID_EN_CLR, ID_DEC_SEL, ID_FREQ_REF,
        ID_CUR_REF, ID_CAL, ID_PON_WRAP, ID_RT_WRAP
    } set_id_t;
    typedef enum logic [1:0] {
        P_IDLE = 2'b00,
        P_HIGH = 2'b01,
        P_LOW  = 2'b11
    } pstate_t;
endpackage : mon_pkg

// >>> hdl/meter_if.sv
// carrier between the top and one hour meter
// assumes both ends share the top's clock
interface meter_if;
    logic        en;
    logic        clr;
    logic        tick;
    logic [15:0] hours;
    logic [15:0] wraps;
    modport meter (input en, clr, output tick, hours, wraps);
    modport user  (output en, clr, input tick, hours, wraps);
endinterface : meter_if

// >>> hdl/hour_meter.sv
// one hour meter: prescaler, 16-bit hour count, wrap count
// assumes en and clr come from logic on the same clock
module hour_meter import mon_pkg::*; #(
    parameter logic [35:0] HOUR_CYCLES = HOUR_CYC // cycles per hour
) (
    input  wire logic   i_clock, // system clock
    input  wire logic   i_rst_b, // async reset, active low
    meter_if.meter      m        // enable, clear, counts
);
    logic [35:0] pre_q;
    logic [15:0] hours_q;
    logic [15:0] wraps_q;
    wire         tick  = m.en && (pre_q == HOUR_CYCLES - 36'h1);
    wire         wrap  = tick && !m.clr && (hours_q == HOUR_MAX);
    wire  [15:0] base  = m.clr ? CLR_VAL : hours_q;

    // [RL19] prescaler to one tick per hour
    // dropping en restarts the hour, so only whole unbroken hours count
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) pre_q <= '0;
        else if (!m.en || m.clr || tick) pre_q <= '0;
        else pre_q <= pre_q + 36'h1;
    end

    // [RL3] wrap to zero and count wraps
    // a tick in the clearing cycle still counts
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hours_q <= '0;
            wraps_q <= '0;
        end else begin
            hours_q <= base + {15'h0000, tick};
            if (wrap) wraps_q <= wraps_q + 16'h0001;
        end
    end

    assign m.tick  = tick;
    assign m.hours = hours_q;
    assign m.wraps = wraps_q;

    wrap_count_a: assert property (@(posedge i_clock) disable iff (!i_rst_b) // [RL3]
        wrap |=> hours_q == 16'h0000 && wraps_q == $past(wraps_q) + 16'h0001)
        else $error("hour meter wrap miscounted");
endmodule : hour_meter

// >>> hdl/monitor_pulse_and_hour_meters.sv
// monitor block: hour meters, display digit shaping, pulse monitor
// assumes all inputs come from logic on i_clock; nonvolatile hour
// storage sits outside and is not modelled here
//
// Contract
// [RL1] power-on meter counts hours, shown at 20
// [RL2] run meter counts running hours, shown at 23
// [RL3] meters wrap past 65535, wraps counted
// [RL4] run meter needs a continuous running hour
// [RL5] clear value 0 clears run meter, reads 9999
// [RL6] power-on meter cannot be cleared
// [RL7] energy clear setting reads 9999 or 10
// [RL8] digit select 9999 unaltered, 0 rounds
// [RL9] digit select 1 drops hundredths digit
// [RL10] hour and energy monitors keep their digits
// [RL11] frequency reference gives 1440 pulses/s
// [RL12] current reference gives 1440 pulses/s
// [RL13] rate proportional, never above 2400/s
// [RL14] references writable despite write protect
// [RL15] references writable only with extended display 0
// [RL16] calibration sets pulse width only
// [RL17] function 21 gives constant 1440 pulses/s
// [RL18] default scale saturates at 100 Hz
// [RL19] hour ticks from clock prescaler, run gated
module monitor_pulse_and_hour_meters import mon_pkg::*; #(
    parameter logic [35:0] HOUR_CYCLES   = HOUR_CYC, // cycles per hour
    parameter logic [15:0] RATED_CURRENT = 16'h01f4  // 0.01 A units
) (
    input  wire logic    i_clock,                        // 10 MHz clock
    input  wire logic    i_rst_b,                        // async reset
    input  wire logic    i_running,                      // drive running
    input  wire logic [15:0] i_frequency,                // 0.01 Hz
    input  wire logic [15:0] i_current,                  // 0.01 A
    input  wire logic [15:0] i_monitor_value,            // general monitor
    input  wire logic [1:0]  i_monitor_decimals,         // its decimals
    input  wire logic [15:0] i_energy_value,             // energy monitor
    input  wire logic [7:0]  i_display_selector,         // monitor code
    input  wire logic [7:0]  i_pulse_output_function_select, // pulse source
    input  wire logic [15:0] i_extended_display_select,  // 0 shows all
    input  wire logic [15:0] i_param_write_protect,      // 1 locks
    input  wire logic    i_set_wr,                       // setting write
    input  set_id_t      i_set_id,                       // setting id
    input  wire logic [15:0] i_set_data,                 // write value
    input  set_id_t      i_get_id,                       // read id
    output logic [15:0]  o_get_data,                     // read value
    output logic [15:0]  o_display_value,                // shown value
    output logic [1:0]   o_display_decimals,             // shown decimals
    output logic         o_energy_clear,                 // clear pulse
    output logic         o_pulse_monitor_output          // pulse train
);
    meter_if pon_if ();
    meter_if run_if ();

    logic [15:0] dec_sel_q;
    logic [15:0] freq_ref_q;
    logic [15:0] cur_ref_q;
    logic [15:0] cal_q;
    logic [15:0] en_mode_q;
    logic [9:0]  step_q;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [12:0] cnt_q;
    logic [12:0] cnt_d;
    logic [12:0] wid_q;
    logic [12:0] since_q;
    pstate_t     state_q;
    pstate_t     state_d;

    function automatic logic [17:0] shape(input logic [15:0] v, input logic [1:0] d,
                                          input logic [15:0] mode);
        logic [15:0] r;
        logic [1:0]  rd;
        r  = v;
        rd = d;
        if (mode == DEC_INT && d == DP_TENTHS) begin
            r  = (v < BELOW_T) ? CLR_VAL : 16'((17'(v) + HALF10) / DIV10);
            rd = DP_NONE;
        end else if (mode == DEC_INT && d == DP_HUND) begin
            r  = (v < BELOW_H) ? CLR_VAL : 16'((17'(v) + HALF100) / DIV100);
            rd = DP_NONE;
        end else if (mode == DEC_TENTH && d == DP_HUND) begin
            r  = 16'(17'(v) / DIV10);
            rd = DP_TENTHS;
        end
        return {rd, r};
    endfunction : shape

    // setting writes
    wire ord_ok = i_param_write_protect != WP_LOCK;
    wire ext_ok = i_extended_display_select == EXT_ALL;
    wire wr_rt  = i_set_wr && i_set_id == ID_RT_CLR && ord_ok;
    // [RL5] only zero clears, 9999 leaves it
    wire rt_clear = wr_rt && i_set_data == CLR_VAL;
    wire en_code  = i_set_data == CLR_VAL || i_set_data == EN_MODE10 || i_set_data == KEEP;
    wire wr_en    = i_set_wr && i_set_id == ID_EN_CLR && ord_ok && en_code;
    wire dec_code = i_set_data == KEEP || i_set_data == DEC_INT || i_set_data == DEC_TENTH;
    wire wr_dec   = i_set_wr && i_set_id == ID_DEC_SEL && ord_ok && dec_code;
    // [RL14] pulse settings ignore write protect and run state
    // [RL15] pulse settings need extended display 0
    wire wr_fref  = i_set_wr && i_set_id == ID_FREQ_REF && ext_ok && i_set_data <= FREQ_REF_MAX;
    wire wr_cref  = i_set_wr && i_set_id == ID_CUR_REF && ext_ok && i_set_data <= CUR_REF_MAX;
    wire wr_cal   = i_set_wr && i_set_id == ID_CAL && ext_ok;

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            dec_sel_q  <= KEEP;
            freq_ref_q <= FREQ_REF_DEF;
            cur_ref_q  <= RATED_CURRENT;
            cal_q      <= CAL_DEF;
        end else begin
            if (wr_dec) dec_sel_q <= i_set_data;
            if (wr_fref) freq_ref_q <= i_set_data;
            if (wr_cref) cur_ref_q <= i_set_data;
            if (wr_cal) cal_q <= i_set_data;
        end
    end

    // [RL7] a zero write keeps the stored mode
    // zero only fires the clear pulse, the reading stays 9999 or 10
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            en_mode_q      <= KEEP;
            o_energy_clear <= 1'b0;
        end else begin
            o_energy_clear <= wr_en && i_set_data == CLR_VAL;
            if (wr_en && i_set_data != CLR_VAL) en_mode_q <= i_set_data;
        end
    end

    // [RL1] power-on meter always enabled
    // [RL6] no clear path for the power-on meter
    assign pon_if.en  = 1'b1;
    assign pon_if.clr = 1'b0;
    // [RL2] run meter enabled while running
    // [RL4] stopping discards the partial hour
    assign run_if.en  = i_running;
    assign run_if.clr = rt_clear;

    hour_meter #(.HOUR_CYCLES(HOUR_CYCLES)) u_pon (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .m       (pon_if.meter)
    );
    hour_meter #(.HOUR_CYCLES(HOUR_CYCLES)) u_run (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .m       (run_if.meter)
    );

    // [RL5] clear setting always reads 9999
    // [RL3] wrap counts read as settings
    wire [15:0] get_w =
        (i_get_id == ID_RT_CLR)   ? KEEP :
        (i_get_id == ID_EN_CLR)   ? en_mode_q :
        (i_get_id == ID_DEC_SEL)  ? dec_sel_q :
        (i_get_id == ID_FREQ_REF) ? freq_ref_q :
        (i_get_id == ID_CUR_REF)  ? cur_ref_q :
        (i_get_id == ID_CAL)      ? cal_q :
        (i_get_id == ID_PON_WRAP) ? pon_if.wraps :
        (i_get_id == ID_RT_WRAP)  ? run_if.wraps : CLR_VAL;

    // display path
    wire        sel_pon = i_display_selector == SEL_PON;
    wire        sel_run = i_display_selector == SEL_RUN;
    wire        sel_en  = i_display_selector == SEL_ENERGY;
    // [RL8] [RL9] digit shaping on general monitors
    wire [17:0] shaped  = shape(i_monitor_value, i_monitor_decimals, dec_sel_q);
    // [RL10] hour and energy monitors bypass shaping
    wire [15:0] disp_v  = sel_pon ? pon_if.hours : sel_run ? run_if.hours :
                          sel_en ? i_energy_value : shaped[15:0];
    wire [1:0]  disp_d  = (sel_pon || sel_run) ? DP_NONE :
                          sel_en ? i_monitor_decimals : shaped[17:16];

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_get_data         <= '0;
            o_display_value    <= '0;
            o_display_decimals <= DP_NONE;
        end else begin
            o_get_data         <= get_w;
            o_display_value    <= disp_v;
            o_display_decimals <= disp_d;
        end
    end

    // pulse rate: acc gains value*1440 per 10 kHz step, a pulse costs ref*10000
    wire        fn_ref  = i_pulse_output_function_select == FN_REF;
    wire        fn_cur  = i_pulse_output_function_select == FN_CURR;
    wire        fn_frq  = i_pulse_output_function_select == FN_FREQ;
    // [RL11] [RL12] pick the scaling reference
    wire [15:0] ref_v   = fn_cur ? cur_ref_q : freq_ref_q;
    // [RL17] reference output uses the reference itself as value
    wire [15:0] mon_v   = fn_ref ? ref_v : fn_cur ? i_current : fn_frq ? i_frequency : CLR_VAL;
    wire [31:0] add_w   = 32'(mon_v) * FULL_MUL;
    wire [31:0] thr_w   = 32'(ref_v) * STEP_MUL;
    wire        step_en = step_q == STEP_LAST;
    wire        pend    = acc_q >= thr_w;
    wire        take    = pend && state_q == P_IDLE;
    wire [12:0] width_w = (cal_q == CLR_VAL) ? 13'h0001 :
                          (cal_q > 16'(PER_LAST)) ? PER_LAST : cal_q[12:0];

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) step_q <= '0;
        else if (step_en) step_q <= '0;
        else step_q <= step_q + 10'h001;
    end

    // [RL13] proportional rate, accumulation held while a pulse waits
    // holding keeps the backlog bounded when the rate caps at 2400/s
    always_comb begin
        acc_d = acc_q;
        if (take) acc_d = acc_q - thr_w;
        else if (step_en && !pend) acc_d = acc_q + add_w;
    end

    // [RL16] width from calibration, spacing from the rate
    // [RL18] period never below the 2400/s minimum, so rates saturate
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 13'h0001;
        case (state_q)
            P_IDLE: begin
                cnt_d = '0;
                if (take) state_d = P_HIGH;
            end
            P_HIGH: if (cnt_q == wid_q - 13'h0001) state_d = P_LOW;
            P_LOW: if (cnt_q >= PER_LAST) state_d = P_IDLE;
            default: state_d = P_IDLE;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acc_q   <= '0;
            state_q <= P_IDLE;
            cnt_q   <= '0;
            wid_q   <= 13'h0001;
            o_pulse_monitor_output <= 1'b0;
        end else begin
            acc_q   <= acc_d;
            state_q <= state_d;
            cnt_q   <= cnt_d;
            if (take) wid_q <= width_w;
            o_pulse_monitor_output <= state_d == P_HIGH;
        end
    end

    // cycles since the last pulse start, for checking only
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) since_q <= PER_LAST;
        else if (take) since_q <= '0;
        else if (since_q != PER_LAST) since_q <= since_q + 13'h0001;
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    sequence s_start;
        take;
    endsequence
    sequence s_high_run;
        o_pulse_monitor_output[*2];
    endsequence

    rt_readback_a: assert property (i_get_id == ID_RT_CLR |=> o_get_data == KEEP) // [RL5]
        else $error("run clear setting did not read 9999");
    rt_clear_a: assert property (rt_clear |=> run_if.hours <= 16'h0001) // [RL5]
        else $error("run meter not cleared by zero");
    rt_keep_a: assert property (wr_rt && i_set_data == KEEP && !run_if.tick // [RL5]
        |=> $stable(run_if.hours))
        else $error("9999 changed the run meter");
    stop_hold_a: assert property (!i_running && !rt_clear |=> $stable(run_if.hours)) // [RL2]
        else $error("run meter moved while stopped");
    // an hour of two cycles or less may legally tick right after a restart
    stop_restart_a: assert property ((!i_running && HOUR_CYCLES > 36'h2) ##1 i_running[*2] |-> !run_if.tick) // [RL4]
        else $error("run hour counted without a full hour");
    pon_noclr_a: assert property (!pon_if.tick |=> $stable(pon_if.hours)) // [RL6]
        else $error("power-on meter changed without a tick");
    en_readback_a: assert property (i_get_id == ID_EN_CLR // [RL7]
        |=> o_get_data == KEEP || o_get_data == EN_MODE10)
        else $error("energy clear setting read back wrong");
    dec_bypass_a: assert property (dec_sel_q == KEEP && !sel_pon && !sel_run && !sel_en // [RL8]
        |=> o_display_value == $past(i_monitor_value))
        else $error("monitor altered with digit select 9999");
    dec_tenth_a: assert property (dec_sel_q == DEC_TENTH && i_monitor_decimals == DP_HUND // [RL9]
        && !sel_pon && !sel_run && !sel_en |=> o_display_decimals == DP_TENTHS)
        else $error("hundredths digit not dropped");
    hours_disp_a: assert property (sel_pon // [RL10]
        |=> o_display_value == $past(pon_if.hours) && o_display_decimals == DP_NONE)
        else $error("power-on hours not shown unchanged");
    ext_gate_a: assert property (i_set_wr && i_set_id == ID_FREQ_REF && !ext_ok // [RL15]
        |=> $stable(freq_ref_q))
        else $error("reference written while hidden");
    wp_bypass_a: assert property (wr_fref && !ord_ok |=> freq_ref_q == $past(i_set_data)) // [RL14]
        else $error("reference blocked by write protect");
    pulse_space_a: assert property (s_start |-> since_q >= PER_LAST) // [RL13]
        else $error("pulses closer than the 2400/s limit");
    pulse_width_a: assert property ($fell(o_pulse_monitor_output) |-> cnt_q == wid_q) // [RL16]
        else $error("pulse width differs from calibration");
    wide_pulse_a: assert property (s_start ##1 (wid_q > 13'h0001) |-> s_high_run) // [RL16]
        else $error("calibrated pulse ended early");
    ref_out_a: assert property (fn_ref |-> add_w * STEP_MUL == thr_w * FULL_MUL) // [RL17]
        else $error("reference output not at full scale");
endmodule : monitor_pulse_and_hour_meters

// >>> sim/pulse_counter.sv
// pulse counter on the monitor pulse pin: counts rises, stamps the
// last rise and measures the last high width in clock cycles
// assumes the pin is sampled on the same clock as the design
module pulse_counter (
    input  wire logic        i_clock,     // system clock
    input  wire logic        i_rst_b,     // async reset, active low
    input  wire logic        i_pulse,     // monitored pin
    output logic      [31:0] o_rises,     // rising edges seen
    output logic      [31:0] o_last_rise, // cycle stamp of last rise
    output logic      [31:0] o_width      // last high width
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] now_q;
    logic [31:0] hi_q;
    logic        prev_q;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            now_q       <= 32'h0;
            hi_q        <= 32'h0;
            prev_q      <= 1'b0;
            o_rises     <= 32'h0;
            o_last_rise <= 32'h0;
            o_width     <= 32'h0;
        end else begin
            now_q  <= now_q + 32'h1;
            prev_q <= i_pulse;
            if (i_pulse) hi_q <= hi_q + 32'h1;
            if (i_pulse && !prev_q) begin
                o_rises     <= o_rises + 32'h1;
                o_last_rise <= now_q;
                hi_q        <= 32'h1;
            end
            if (!i_pulse && prev_q) o_width <= hi_q;
        end
    end
endmodule : pulse_counter

// >>> sim/monitor_pulse_and_hour_meters_test.sv
// bench for the monitor block: settings, hour meters, display, pulses
// assumes a 50-cycle hour; a second copy with a 1-cycle hour checks wrap
module monitor_pulse_and_hour_meters_test import mon_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clock = 1'b0, i_rst_b = 1'b0, i_running = 1'b0, i_set_wr = 1'b0;
    logic [15:0] i_frequency = 16'h0, i_current = 16'h0, i_monitor_value = 16'h0, i_energy_value = 16'h1234;
    logic [15:0] i_extended_display_select = 16'h0, i_param_write_protect = 16'h0, i_set_data = 16'h0;
    logic [1:0]  i_monitor_decimals = 2'h0;
    logic [7:0]  i_display_selector = SEL_PON, i_pulse_output_function_select = 8'h0;
    set_id_t     i_set_id = ID_RT_CLR, i_get_id = ID_RT_CLR;
    logic [15:0] o_get_data, o_display_value, wrap_get;
    logic [1:0]  o_display_decimals;
    logic        o_energy_clear, o_pulse_monitor_output;
    logic [31:0] rises, last_rise, width;
    int          mismatches = 0, checked = 0, cycles = 0;
    always #50 i_clock = ~i_clock;
    monitor_pulse_and_hour_meters #(.HOUR_CYCLES(36'd50)) dut_u (.i_clock, .i_rst_b, .i_running,
        .i_frequency, .i_current, .i_monitor_value, .i_monitor_decimals, .i_energy_value,
        .i_display_selector, .i_pulse_output_function_select, .i_extended_display_select,
        .i_param_write_protect, .i_set_wr, .i_set_id, .i_set_data, .i_get_id, .o_get_data,
        .o_display_value, .o_display_decimals, .o_energy_clear, .o_pulse_monitor_output);
    // short hour so the power-on meter wraps within the run
    monitor_pulse_and_hour_meters #(.HOUR_CYCLES(36'd1)) wrap_u (.i_clock, .i_rst_b, .i_running,
        .i_frequency, .i_current, .i_monitor_value, .i_monitor_decimals, .i_energy_value,
        .i_display_selector, .i_pulse_output_function_select, .i_extended_display_select,
        .i_param_write_protect, .i_set_wr, .i_set_id, .i_set_data, .i_get_id, .o_get_data(wrap_get),
        .o_display_value(), .o_display_decimals(), .o_energy_clear(), .o_pulse_monitor_output());
    pulse_counter meter_u (.i_clock, .i_rst_b, .i_pulse(o_pulse_monitor_output),
        .o_rises(rises), .o_last_rise(last_rise), .o_width(width));
    task automatic end_sim;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input set_id_t id, input logic [15:0] d);
        @(negedge i_clock);
        i_set_id   = id;
        i_set_data = d;
        i_set_wr   = 1'b1;
        @(negedge i_clock);
        i_set_wr = 1'b0;
    endtask : wr
    task automatic rd(input set_id_t id, input logic [15:0] exp);
        @(negedge i_clock);
        i_get_id = id;
        repeat (2) @(negedge i_clock);
        check(o_get_data, exp);
    endtask : rd
    task automatic show(input logic [15:0] v, input logic [1:0] d, input logic [15:0] ev, input logic [1:0] ed);
        @(negedge i_clock);
        i_monitor_value    = v;
        i_monitor_decimals = d;
        repeat (2) @(negedge i_clock);
        check(o_display_value, ev);
        check(o_display_decimals, ed);
    endtask : show
    // rate measured over n periods after one rise to resync
    task automatic meas(input int n, input int lo, input int hi);
        logic [31:0] c0, t0;
        int          k;
        k  = 0;
        c0 = rises;
        while (rises == c0 && k < 20000) begin @(negedge i_clock); k++; end
        c0 = rises;
        t0 = last_rise;
        k  = 0;
        while (rises < c0 + n && k < 20000) begin @(negedge i_clock); k++; end
        check({31'h0, (last_rise - t0 >= lo) && (last_rise - t0 <= hi)}, 32'h1);
    endtask : meas
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 98000) begin
            mismatches++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (175) @(negedge i_clock);
        check(o_display_value, 16'h3);
        check(o_display_decimals, 2'h0);
        rd(ID_RT_CLR, KEEP);
        rd(ID_EN_CLR, KEEP);
        rd(ID_DEC_SEL, KEEP);
        rd(ID_FREQ_REF, FREQ_REF_DEF);
        rd(ID_CUR_REF, 16'h01f4);
        rd(ID_CAL, CAL_DEF);
        rd(ID_PON_WRAP, 16'h0);
        i_display_selector = SEL_RUN;
        i_running = 1'b1;
        repeat (125) @(negedge i_clock);
        check(o_display_value, 16'h2);
        // a one-cycle stop discards the partial hour
        i_running = 1'b0;
        @(negedge i_clock);
        i_running = 1'b1;
        repeat (40) @(negedge i_clock);
        i_running = 1'b0;
        repeat (100) @(negedge i_clock);
        check(o_display_value, 16'h2);
        wr(ID_RT_CLR, KEEP);
        repeat (3) @(negedge i_clock);
        check(o_display_value, 16'h2);
        wr(ID_RT_CLR, CLR_VAL);
        repeat (3) @(negedge i_clock);
        check(o_display_value, 16'h0);
        rd(ID_RT_CLR, KEEP);
        i_display_selector = SEL_PON;
        repeat (3) @(negedge i_clock);
        check({31'h0, o_display_value >= 16'h8}, 32'h1);
        wr(ID_EN_CLR, CLR_VAL);
        check(o_energy_clear, 1'b1);
        @(negedge i_clock);
        check(o_energy_clear, 1'b0);
        rd(ID_EN_CLR, KEEP);
        wr(ID_EN_CLR, EN_MODE10);
        rd(ID_EN_CLR, EN_MODE10);
        i_extended_display_select = 16'h1;
        wr(ID_FREQ_REF, 16'h03e8);
        rd(ID_FREQ_REF, FREQ_REF_DEF);
        i_extended_display_select = EXT_ALL;
        i_param_write_protect = WP_LOCK;
        i_running = 1'b1;
        wr(ID_FREQ_REF, 16'h0bb8);
        rd(ID_FREQ_REF, 16'h0bb8);
        wr(ID_DEC_SEL, DEC_INT);
        rd(ID_DEC_SEL, KEEP);
        i_param_write_protect = 16'h0;
        wr(ID_FREQ_REF, 16'h9c41);
        rd(ID_FREQ_REF, 16'h0bb8);
        wr(ID_FREQ_REF, FREQ_REF_DEF);
        i_display_selector = 8'h00;
        show(16'h04d2, DP_HUND, 16'h04d2, DP_HUND);
        wr(ID_DEC_SEL, DEC_INT);
        show(16'd123, DP_TENTHS, 16'd12, DP_NONE);
        show(16'd9, DP_TENTHS, 16'd0, DP_NONE);
        show(16'd250, DP_HUND, 16'd3, DP_NONE);
        show(16'd98, DP_HUND, 16'd0, DP_NONE);
        i_display_selector = SEL_ENERGY;
        repeat (3) @(negedge i_clock);
        check(o_display_value, 16'h1234);
        i_display_selector = 8'h00;
        wr(ID_DEC_SEL, DEC_TENTH);
        show(16'd1234, DP_HUND, 16'd123, DP_TENTHS);
        show(16'd77, DP_NONE, 16'd77, DP_NONE);
        wr(ID_CAL, 16'd100);
        i_frequency = 16'd6000;
        i_pulse_output_function_select = FN_FREQ;
        meas(1, 5900, 7100);
        check(width, 32'd100);
        i_frequency = 16'h0;
        i_pulse_output_function_select = FN_REF;
        meas(1, 6900, 7000);
        i_current = 16'h01f4;
        i_pulse_output_function_select = FN_CURR;
        meas(1, 5900, 7100);
        i_frequency = 16'd10000;
        i_pulse_output_function_select = FN_FREQ;
        meas(3, 12500, 15100);
        i_frequency = 16'd3000;
        meas(1, 12800, 15000);
        while (cycles < 70000) @(negedge i_clock);
        @(negedge i_clock);
        i_get_id = ID_PON_WRAP;
        repeat (2) @(negedge i_clock);
        check(wrap_get, 16'h1);
        end_sim();
    end
endmodule : monitor_pulse_and_hour_meters_test
